// ### pldma_pkg.sv
package pldma_pkg;

    // Array geometry.
    localparam int MC_COUNT = 24;
    localparam int DED_INPUTS = 14;
    localparam int PT_PER_MC = 17;
    localparam int PT_SUM = 12;
    localparam int PT_PER_SUM = 4;
    localparam int SUM_PER_MC = 3;
    localparam int BUS_WIDTH = 2 * DED_INPUTS + 6 * MC_COUNT;
    localparam int PRESET_COUNT = 8;
    localparam int LOAD_GROUP = 12;

    // Dedicated product-term positions inside a macrocell.
    localparam int PT_AR1 = 12;
    localparam int PT_CK1 = 13;
    localparam int PT_CK2 = 14;
    localparam int PT_AR2 = 15;
    localparam int PT_OE = 16;

    // Values after reset.
    localparam logic RST_REG_VAL = 1'h0;
    localparam logic RST_KEEP_VAL = 1'h0;

    // Configuration image sizes, in fuses.
    localparam int IMG_LEGACY_A_FUSES = 71648;
    localparam int IMG_LEGACY_B_FUSES = 71745;
    localparam int IMG_NATIVE_FUSES = 71816;

    // Power-up reset time in ns and its cycle count at 250 MHz.
    localparam int PWRUP_NS = 1000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int PWRUP_CYCLES = PWRUP_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        PLDMA_IMG_LEGACY_A = 3'h1,
        PLDMA_IMG_LEGACY_B = 3'h2,
        PLDMA_IMG_NATIVE = 3'h4
    } pldma_img_e;

    // Per-macrocell configuration bits.
    typedef struct packed {
        logic [PT_PER_MC-1:0][BUS_WIDTH-1:0] and_true;
        logic [PT_PER_MC-1:0][BUS_WIDTH-1:0] and_used;
        logic [1:0] comb_sel;
        logic comb_out;
        logic active_high;
        logic t1_type;
        logic t2_type;
        logic pin_clk1;
        logic pin_clk2;
        logic fb_from_input;
    } pldma_mc_cfg_s;

    // Test-mode pin group.
    typedef struct packed {
        logic load_mode;
        logic observe_mode;
        logic load_strobe;
        logic reg_select;
        logic odd_select;
    } pldma_test_s;

endpackage : pldma_pkg

// ### pldma_array.sv
`timescale 1ns/10ps
`default_nettype none

module pldma_array #(
    parameter pldma_pkg::pldma_img_e IMAGE = pldma_pkg::PLDMA_IMG_NATIVE,
    parameter bit KEEPER_BIT = 1'b0,
    parameter int PWRUP_COUNT = pldma_pkg::PWRUP_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [pldma_pkg::DED_INPUTS-1:0] ded_in,
    input wire logic [pldma_pkg::DED_INPUTS-1:0] ded_in_driven,
    input wire logic pin_clk,
    input wire logic [pldma_pkg::MC_COUNT-1:0] io_in,
    input wire logic [pldma_pkg::MC_COUNT-1:0] io_driven,
    output logic [pldma_pkg::MC_COUNT-1:0] io_out,
    output logic [pldma_pkg::MC_COUNT-1:0] io_oe,
    input wire pldma_pkg::pldma_mc_cfg_s [pldma_pkg::MC_COUNT-1:0] mc_cfg,
    input wire logic [pldma_pkg::PRESET_COUNT-1:0][pldma_pkg::BUS_WIDTH-1:0] preset_true,
    input wire logic [pldma_pkg::PRESET_COUNT-1:0][pldma_pkg::BUS_WIDTH-1:0] preset_used,
    input wire pldma_pkg::pldma_test_s test_pins,
    input wire logic security_fuse,
    input wire logic verify_in,
    output logic verify_out,
    output logic keeper_active,
    output logic powerup_done
);
    import pldma_pkg::*;

    localparam int PW = 3;

    // Every pin-side input, driven flags included, is one vector so all bits share the same latency.
    localparam int PN = 2 * DED_INPUTS + 2 * MC_COUNT + 6;

    // Pins come from another domain: three stages, change accepted when stages two and three agree.
    logic [PW-1:0][PN-1:0] pin_sync_ff;
    logic [PN-1:0] pin_state_ff;
    logic [PN-1:0] pin_raw;
    logic [PN-1:0] nxt_pin_state;

    // A driven flag sampled apart from its level would let the keeper latch a stale value.
    assign pin_raw = {ded_in, ded_in_driven, io_in, io_driven, pin_clk, test_pins};

    // Synchroniser chain; the first stage feeds only the second.
    // Reset clears the chain, so a pin held high at release shows as a change a few cycles later.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_sync_ff <= '0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[PW-2:0], pin_raw};
        end
    end

    // Accept a change only once stages two and three agree, so a single-cycle glitch is ignored.
    always_comb begin
        for (int b = 0; b < PN; b++) begin
            nxt_pin_state[b] = (pin_sync_ff[1][b] == pin_sync_ff[2][b]) ? pin_sync_ff[2][b] : pin_state_ff[b];
        end
    end

    // Settled pin levels, updated only when the last two stages agree.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_state_ff <= '0;
        end else begin
            pin_state_ff <= nxt_pin_state;
        end
    end

    // Settled pin fields, in the same order as the raw vector.
    logic [DED_INPUTS-1:0] ded_lvl;
    logic [DED_INPUTS-1:0] ded_drv;
    logic [MC_COUNT-1:0] io_lvl;
    logic [MC_COUNT-1:0] io_drv;
    logic pclk_lvl;
    pldma_test_s tst;
    assign {ded_lvl, ded_drv, io_lvl, io_drv, pclk_lvl, tst} = pin_state_ff;

    // Legacy images strip T-type, pin clocking and input feedback.
    localparam bit LEGACY = (IMAGE != PLDMA_IMG_NATIVE);
    // The keeper is a build-time variant; legacy images force it off.
    localparam bit KEEP_EN = (IMAGE == PLDMA_IMG_NATIVE) && KEEPER_BIT;

    // Reported so the board side can tell whether floating pins are held.
    assign keeper_active = KEEP_EN;

    // Power-up reset: registers held clear for the power-up time after rst releases.
    // The counter saturates, so powerup_done stays high until the next reset.
    logic [15:0] pwr_cnt_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            pwr_cnt_ff <= '0;
        end else if (pwr_cnt_ff != 16'(PWRUP_COUNT)) begin
            pwr_cnt_ff <= pwr_cnt_ff + 16'h0001;
        end
    end
    assign powerup_done = (pwr_cnt_ff == 16'(PWRUP_COUNT));

    // The security fuse locks out both test modes.
    // Loading also waits for powerup_done, since the register processes give power-up clear priority.
    logic load_act;
    logic obs_act;
    assign load_act = tst.load_mode & ~security_fuse;
    assign obs_act = tst.observe_mode & ~security_fuse;

    // Strobe rising edge, taken from the settled pin level.
    // Holding the strobe high does not repeat the load; only its rising edge counts.
    logic strobe_d_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            strobe_d_ff <= 1'h0;
        end else begin
            strobe_d_ff <= tst.load_strobe;
        end
    end
    logic load_pulse;
    assign load_pulse = load_act & tst.load_strobe & ~strobe_d_ff;

    // Keeper state: last driven level of each pin; an I/O pin also keeps its own output while it drives.
    logic [MC_COUNT-1:0] io_keep_ff;
    logic [DED_INPUTS-1:0] ded_keep_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            io_keep_ff <= {MC_COUNT{RST_KEEP_VAL}};
            ded_keep_ff <= {DED_INPUTS{RST_KEEP_VAL}};
        end else begin
            // Each pin selects on its own bit, so one driven pin never refreshes the others.
            io_keep_ff <= (io_drv & io_lvl) | (~io_drv & io_oe & io_out) | (~io_drv & ~io_oe & io_keep_ff);
            ded_keep_ff <= (ded_drv & ded_lvl) | (~ded_drv & ded_keep_ff);
        end
    end

    // Undriven pins read the held level when keepers exist; a driver always wins.
    // Without keepers an undriven pin reads low rather than unknown, keeping the array free of X.
    logic [MC_COUNT-1:0] io_eff;
    logic [DED_INPUTS-1:0] ded_eff;
    always_comb begin
        for (int i = 0; i < MC_COUNT; i++) begin
            io_eff[i] = io_drv[i] ? io_lvl[i] : (io_oe[i] ? io_out[i] : (KEEP_EN ? io_keep_ff[i] : 1'b0));
        end
        for (int j = 0; j < DED_INPUTS; j++) begin
            ded_eff[j] = ded_drv[j] ? ded_lvl[j] : (KEEP_EN ? ded_keep_ff[j] : 1'b0);
        end
    end

    // Global bus: every array connection goes through this one vector.
    // Bus order fixes which fuse column a product term reads.
    logic [BUS_WIDTH-1:0] gbus;
    logic [MC_COUNT-1:0] fb2;
    logic [MC_COUNT-1:0] q1_ff;
    logic [MC_COUNT-1:0] q2_ff;
    logic [MC_COUNT-1:0] d2;
    always_comb begin
        gbus = '0;
        for (int j = 0; j < DED_INPUTS; j++) begin
            gbus[2*j] = ded_eff[j];
            gbus[2*j+1] = ~ded_eff[j];
        end
        for (int m = 0; m < MC_COUNT; m++) begin
            gbus[2*DED_INPUTS+6*m] = fb2[m];
            gbus[2*DED_INPUTS+6*m+1] = ~fb2[m];
            gbus[2*DED_INPUTS+6*m+2] = q1_ff[m];
            gbus[2*DED_INPUTS+6*m+3] = ~q1_ff[m];
            gbus[2*DED_INPUTS+6*m+4] = io_eff[m];
            gbus[2*DED_INPUTS+6*m+5] = ~io_eff[m];
        end
    end

    // Shared synchronous presets; used bits with true=0 take the complement column.
    // A preset with no used bits is always true, so an unused one needs a contradiction in it.
    logic [PRESET_COUNT-1:0] preset_pt;
    always_comb begin
        for (int p = 0; p < PRESET_COUNT; p++) begin
            preset_pt[p] = &(~preset_used[p] | ~(gbus ^ preset_true[p]));
        end
    end

    // Pin-clock level delayed one cycle; macrocells gate their clock with pclk_lvl and do not read it.
    // The pin clock is only a gate on clock terms; it never clocks a register by itself.
    logic pclk_d_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            pclk_d_ff <= 1'h0;
        end else begin
            pclk_d_ff <= pclk_lvl;
        end
    end

    genvar g;
    generate
        for (g = 0; g < MC_COUNT; g++) begin : gen_mc
            // Per-macrocell product terms, sums, clock edges and load selects.
            logic [PT_PER_MC-1:0] pt;
            logic [SUM_PER_MC-1:0] sum;
            logic d1;
            logic ck1_ff;
            logic ck2_ff;
            logic ck1_rise;
            logic ck2_rise;
            logic comb_val;
            logic psel;
            logic t1;
            logic t2;
            logic pin1;
            logic pin2;
            logic fb_in;
            logic ld_here1;
            logic ld_here2;
            // Presets group as 4,2,4,2,...: index from macrocell position in each group of six.
            localparam int PIDX = (g / 6) * 2 + ((g % 6) >= 4 ? 1 : 0);
            // Parity of this macrocell, compared with the even/odd select pin.
            localparam bit MC_ODD = (g % 2) == 1;

            // Seventeen AND gates, each seeing the whole global bus.
            for (genvar k = 0; k < PT_PER_MC; k++) begin : gen_pt
                assign pt[k] = &(~mc_cfg[g].and_used[k] | ~(gbus ^ mc_cfg[g].and_true[k]));
            end
            for (genvar s = 0; s < SUM_PER_MC; s++) begin : gen_sum
                assign sum[s] = |pt[PT_PER_SUM*s +: PT_PER_SUM];
            end

            assign t1 = mc_cfg[g].t1_type & ~LEGACY;
            assign t2 = mc_cfg[g].t2_type & ~LEGACY;
            assign pin1 = mc_cfg[g].pin_clk1 & ~LEGACY;
            assign pin2 = mc_cfg[g].pin_clk2 & ~LEGACY;
            assign fb_in = mc_cfg[g].fb_from_input & ~LEGACY;

            // Sum-term steering: first register gets 4, 8 or 12 terms, buried gets sum two.
            // Codes 0 and 3 both give the eight-term split.
            always_comb begin
                case (mc_cfg[g].comb_sel)
                    2'h1: d1 = sum[0] | sum[1] | sum[2];
                    2'h2: d1 = sum[0];
                    default: d1 = sum[0] | sum[1];
                endcase
            end
            assign d2[g] = sum[2];
            assign comb_val = d1;
            // Input feedback shows the buried sum ahead of the register, saving a cycle of latency.
            assign fb2[g] = fb_in ? d2[g] : q2_ff[g];

            // Clock terms are edge-detected on mclk; a pin-clocked register also needs the pin high.
            // Limitation: a clock term must stay low for a full mclk cycle or its next edge is lost.
            always_ff @(posedge mclk) begin
                if (rst) begin
                    ck1_ff <= 1'h0;
                    ck2_ff <= 1'h0;
                end else begin
                    ck1_ff <= pt[PT_CK1] & (~pin1 | pclk_lvl);
                    ck2_ff <= pt[PT_CK2] & (~pin2 | pclk_lvl);
                end
            end
            assign ck1_rise = pt[PT_CK1] & (~pin1 | pclk_lvl) & ~ck1_ff;
            assign ck2_rise = pt[PT_CK2] & (~pin2 | pclk_lvl) & ~ck2_ff;
            // Both registers of a macrocell share its group's preset term.
            assign psel = preset_pt[PIDX];

            // Twelve registers answer each strobe: one bank, one parity.
            assign ld_here1 = load_pulse & ~tst.reg_select & (tst.odd_select == MC_ODD);
            assign ld_here2 = load_pulse & tst.reg_select & (tst.odd_select == MC_ODD);

            // First register: power-up clear, then load, clear, preset, clock in that priority.
            // A load wins over a clear so that test sequencing can force any state.
            always_ff @(posedge mclk) begin
                if (rst || !powerup_done) begin
                    q1_ff[g] <= RST_REG_VAL;
                end else if (ld_here1) begin
                    q1_ff[g] <= io_lvl[g | 1];
                end else if (pt[PT_AR1]) begin
                    q1_ff[g] <= 1'b0;
                end else if (ck1_rise) begin
                    q1_ff[g] <= psel ? 1'b1 : (t1 ? q1_ff[g] ^ d1 : d1);
                end
            end

            // Buried register, same structure.
            always_ff @(posedge mclk) begin
                if (rst || !powerup_done) begin
                    q2_ff[g] <= RST_REG_VAL;
                end else if (ld_here2) begin
                    q2_ff[g] <= io_lvl[g | 1];
                end else if (pt[PT_AR2]) begin
                    q2_ff[g] <= 1'b0;
                end else if (ck2_rise) begin
                    q2_ff[g] <= psel ? 1'b1 : (t2 ? q2_ff[g] ^ d2[g] : d2[g]);
                end
            end

            // Output: observe mode shows the buried register under the normal enable.
            // Load mode lets go of every output so the tester can drive the odd pins.
            always_ff @(posedge mclk) begin
                if (rst) begin
                    io_out[g] <= 1'b0;
                    io_oe[g] <= 1'b0;
                end else begin
                    io_oe[g] <= pt[PT_OE] & ~load_act;
                    if (obs_act) begin
                        io_out[g] <= q2_ff[g];
                    end else begin
                        io_out[g] <= (mc_cfg[g].comb_out ? comb_val : q1_ff[g]) ^ ~mc_cfg[g].active_high;
                    end
                end
            end
        end
    endgenerate

    // Verify read-back; a set fuse reads programmed at once.
    // The fuse is read live, so masking starts on the very next cycle after it is set.
    always_ff @(posedge mclk) begin
        if (rst) begin
            verify_out <= 1'b0;
        end else begin
            verify_out <= security_fuse | verify_in;
        end
    end

endmodule : pldma_array

`default_nettype wire

// ### pldma_array_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module pldma_array_chk #(
    parameter pldma_pkg::pldma_img_e IMAGE = pldma_pkg::PLDMA_IMG_NATIVE,
    parameter bit KEEPER_BIT = 1'b0,
    parameter int PWRUP_COUNT = pldma_pkg::PWRUP_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [pldma_pkg::MC_COUNT-1:0] io_out,
    input wire logic [pldma_pkg::MC_COUNT-1:0] io_oe,
    input wire pldma_pkg::pldma_mc_cfg_s [pldma_pkg::MC_COUNT-1:0] mc_cfg,
    input wire pldma_pkg::pldma_test_s test_pins,
    input wire logic security_fuse,
    input wire logic verify_in,
    input wire logic verify_out,
    input wire logic keeper_active,
    input wire logic powerup_done
);
    import pldma_pkg::*;
    localparam int PWR_LO = PWRUP_COUNT - 1;
    localparam int PWR_HI = PWRUP_COUNT + 1;
    logic oe_free;
    logic plain_reg;

    // Some checks only make sense when every enable term is constant true or every output is a plain register.
    always_comb begin
        oe_free = 1'b1;
        plain_reg = 1'b1;
        for (int m = 0; m < MC_COUNT; m++) begin
            oe_free = oe_free & (mc_cfg[m].and_used[PT_OE] == '0);
            plain_reg = plain_reg & !mc_cfg[m].comb_out & mc_cfg[m].active_high;
        end
    end

    property p_verify_rd;
        @(posedge mclk) disable iff (rst) !$past(rst) |-> verify_out == ($past(security_fuse) | $past(verify_in));
    endproperty
    a_verify_rd: assert property (p_verify_rd) else $error("verify read-back mismatch");
    property p_keeper;
        @(posedge mclk) disable iff (rst) keeper_active == (IMAGE == PLDMA_IMG_NATIVE && KEEPER_BIT);
    endproperty
    a_keeper: assert property (p_keeper) else $error("keeper enable wrong");
    property p_pwr_window;
        @(posedge mclk) disable iff (rst) $fell(rst) |-> !powerup_done ##[PWR_LO:PWR_HI] powerup_done;
    endproperty
    a_pwr_window: assert property (p_pwr_window) else $error("power-up time wrong");
    property p_pwr_stay;
        @(posedge mclk) disable iff (rst) powerup_done |=> powerup_done;
    endproperty
    a_pwr_stay: assert property (p_pwr_stay) else $error("power-up flag dropped");
    property p_rst_clear;
        @(posedge mclk) rst |=> io_out == '0 && io_oe == '0 && verify_out == 1'b0;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared by reset");
    property p_pre_pwr;
        @(posedge mclk) disable iff (rst) !powerup_done && plain_reg |-> io_out == '0;
    endproperty
    a_pre_pwr: assert property (p_pre_pwr) else $error("register left low state early");
    property p_load_oe;
        @(posedge mclk) disable iff (rst) (!security_fuse && powerup_done && test_pins.load_mode) [*8] |-> io_oe == '0;
    endproperty
    a_load_oe: assert property (p_load_oe) else $error("outputs driven during load");
    property p_fuse_oe;
        @(posedge mclk) disable iff (rst)
            (security_fuse && oe_free && powerup_done && test_pins.load_mode) [*8] |-> io_oe == '1;
    endproperty
    a_fuse_oe: assert property (p_fuse_oe) else $error("load entered with fuse set");
endmodule : pldma_array_chk

bind pldma_array pldma_array_chk #(.IMAGE(IMAGE), .KEEPER_BIT(KEEPER_BIT), .PWRUP_COUNT(PWRUP_COUNT)) u_chk (
    .mclk(mclk), .rst(rst), .io_out(io_out), .io_oe(io_oe), .mc_cfg(mc_cfg), .test_pins(test_pins),
    .security_fuse(security_fuse), .verify_in(verify_in), .verify_out(verify_out),
    .keeper_active(keeper_active), .powerup_done(powerup_done));

`default_nettype wire

// ### pldma_board.sv
`timescale 1ns/10ps
`default_nettype none

module pldma_board (
    input wire logic mclk,
    input wire logic go,
    input wire logic rs,
    input wire logic os,
    input wire logic obs,
    input wire logic [23:0] data,
    output var pldma_pkg::pldma_test_s test_pins,
    output logic [23:0] brd_io,
    output logic [23:0] io_driven,
    output logic busy
);
    import pldma_pkg::*;

    // Tester sequence: raise the mode pin, wait for the outputs to let go, then drive data and pulse the strobe.
    initial begin
        logic start;
        test_pins = '0;
        brd_io = '0;
        io_driven = '0;
        busy = 1'b0;
        forever begin
            @(posedge mclk);
            start = go;
            #1;
            test_pins.observe_mode = obs;
            if (start) begin
                busy = 1'b1;
                test_pins.reg_select = rs;
                test_pins.odd_select = os;
                test_pins.load_mode = 1'b1;
                repeat (6) @(posedge mclk);
                #1 brd_io = data;
                io_driven = '1;
                repeat (6) @(posedge mclk);
                #1 test_pins.load_strobe = 1'b1;
                repeat (6) @(posedge mclk);
                #1 test_pins.load_strobe = 1'b0;
                repeat (6) @(posedge mclk);
                // Released lines show the inverse so that a stale level is never mistaken for a held one.
                #1 io_driven = '0;
                brd_io = ~data;
                test_pins.load_mode = 1'b0;
                busy = 1'b0;
            end
        end
    end
endmodule : pldma_board

`default_nettype wire

// ### pldma_array_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module pldma_array_tb_top;
    import pldma_pkg::*;
    localparam int PWR = 4;
    localparam logic [BUS_WIDTH-1:0] NEVER = {{(BUS_WIDTH-2){1'b0}}, 2'h3};
    typedef struct packed {
        logic rs;
        logic os;
        logic [23:0] data;
        logic [23:0] exp_q1;
        logic [23:0] exp_q2;
    } pldma_row_s;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [DED_INPUTS-1:0] ded_in = '0;
    logic [23:0] io_in, brd_io, io_driven, io_out, io_oe, data = '0, q1_m = '0, q2_m = '0;
    pldma_mc_cfg_s [MC_COUNT-1:0] mc_cfg;
    logic [PRESET_COUNT-1:0][BUS_WIDTH-1:0] preset_term;
    pldma_test_s test_pins;
    logic security_fuse = 1'b0, verify_in = 1'b0, go = 1'b0, rs = 1'b0, os = 1'b0, obs = 1'b0;
    logic verify_out, keeper_active, powerup_done, busy, keeper_legacy;
    int miscompares = 0;
    int comparisons = 0;
    pldma_row_s rows [4] = '{'{1'b0, 1'b0, 24'hC3A55A, 24'h415005, 24'h000000},
                             '{1'b0, 1'b1, 24'h5A3C96, 24'h4B7887, 24'h000000},
                             '{1'b1, 1'b0, 24'h0FF0A5, 24'h4B7887, 24'h055050},
                             '{1'b1, 1'b1, 24'hF00F5A, 24'h4B7887, 24'hA55A5A}};

    // Pin level: the device wins where it drives and the tester does not.
    assign io_in = (brd_io & ~(io_oe & ~io_driven)) | (io_out & io_oe & ~io_driven);

    always #2 mclk = ~mclk;

    pldma_array #(.IMAGE(PLDMA_IMG_NATIVE), .KEEPER_BIT(1'b1), .PWRUP_COUNT(PWR)) dut (
        .mclk(mclk), .rst(rst), .ded_in(ded_in), .ded_in_driven({DED_INPUTS{1'b1}}), .pin_clk(1'b0),
        .io_in(io_in), .io_driven(io_driven), .io_out(io_out), .io_oe(io_oe), .mc_cfg(mc_cfg),
        .preset_true(preset_term), .preset_used(preset_term), .test_pins(test_pins),
        .security_fuse(security_fuse), .verify_in(verify_in), .verify_out(verify_out),
        .keeper_active(keeper_active), .powerup_done(powerup_done));
    // A legacy image with the keeper bit asked for must still come up with keepers off.
    pldma_array #(.IMAGE(PLDMA_IMG_LEGACY_B), .KEEPER_BIT(1'b1), .PWRUP_COUNT(PWR)) dut_legacy (
        .mclk(mclk), .rst(rst), .ded_in(ded_in), .ded_in_driven({DED_INPUTS{1'b1}}), .pin_clk(1'b0),
        .io_in(io_in), .io_driven(io_driven), .io_out(), .io_oe(), .mc_cfg(mc_cfg),
        .preset_true(preset_term), .preset_used(preset_term), .test_pins(test_pins),
        .security_fuse(security_fuse), .verify_in(verify_in), .verify_out(),
        .keeper_active(keeper_legacy), .powerup_done());
    pldma_board board (.mclk(mclk), .go(go), .rs(rs), .os(os), .obs(obs), .data(data),
        .test_pins(test_pins), .brd_io(brd_io), .io_driven(io_driven), .busy(busy));

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle

    task automatic wait_pwr;
        int n;
        n = 0;
        do begin
            settle(1);
            n++;
        end while (powerup_done !== 1'b1 && n < 50);
        settle(8);
    endtask : wait_pwr

    // One tester load; the model follows only when the fuse leaves loading open.
    task automatic do_load(input logic r, input logic o, input logic [23:0] d);
        int n;
        n = 0;
        rs = r;
        os = o;
        data = d;
        ded_in = d[13:0];
        go = 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (busy !== 1'b1 && n < 20);
        check({23'h0, busy}, 24'h000001);
        #1 go = 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (busy !== 1'b0 && n < 60);
        check({23'h0, busy}, 24'h000000);
        settle(10);
        for (int g = 0; g < MC_COUNT; g++) begin
            if (!security_fuse && (g % 2) == int'(o)) begin
                if (r) q2_m[g] = d[g | 1];
                else q1_m[g] = d[g | 1];
            end
        end
    endtask : do_load

    task automatic end_sim;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // Every term but the enable is a contradiction, so registers change only by loads.
    initial begin
        mc_cfg = '0;
        for (int p = 0; p < PRESET_COUNT; p++) begin
            preset_term[p] = NEVER;
        end
        for (int m = 0; m < MC_COUNT; m++) begin
            mc_cfg[m].active_high = 1'b1;
            for (int t = 0; t < PT_OE; t++) begin
                mc_cfg[m].and_true[t] = NEVER;
                mc_cfg[m].and_used[t] = NEVER;
            end
        end
        settle(16);
        rst = 1'b0;
        wait_pwr();
        check({23'h0, keeper_active}, 24'h000001);
        check({23'h0, keeper_legacy}, 24'h000000);
        check(io_out, 24'h000000);
        $display("test power-up done");
        foreach (rows[i]) begin
            do_load(rows[i].rs, rows[i].os, rows[i].data);
            check(io_out, q1_m);
            check(io_out, rows[i].exp_q1);
            obs = 1'b1;
            settle(10);
            check(io_out, rows[i].exp_q2);
            obs = 1'b0;
            settle(10);
        end
        $display("test preload done");
        obs = 1'b1;
        settle(10);
        check(io_out, q2_m);
        obs = 1'b0;
        for (int f = 0; f < 4; f++) begin
            security_fuse = f[1];
            verify_in = f[0];
            settle(3);
            check({23'h0, verify_out}, {23'h0, f[1] | f[0]});
        end
        do_load(1'b0, 1'b0, 24'hFFFFFF);
        check(io_out, q1_m);
        obs = 1'b1;
        settle(10);
        check(io_out, q1_m);
        obs = 1'b0;
        $display("test fuse done");
        rst = 1'b1;
        settle(2);
        check(io_oe, 24'h000000);
        rst = 1'b0;
        wait_pwr();
        check(io_out, 24'h000000);
        $display("test reset done");
        end_sim();
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        end_sim();
    end
endmodule : pldma_array_tb_top

`default_nettype wire
